// >>> src/sbc_cfg_pkg.sv
// Constants for the configuration register bank of the system basis chip:
// frame layout, register addresses, field positions, reset values, timing.
// Assumes one 25 MHz core clock and 16-bit serial frames, most significant bit first.
package sbc_cfg_pkg;

   // Frame layout
   localparam int          FRAME_BITS    = 16;
   localparam int          HDR_BITS      = 3;
   localparam int          ADDR_HI       = 15;
   localparam int          ADDR_LO       = 14;
   localparam int          RSEL_BIT      = 13;
   localparam int          RDO_BIT       = 12;

   // Register addresses in the top two frame bits
   localparam logic [1:0]  ADDR_SYSCFG   = 2'h2;
   localparam logic [1:0]  ADDR_PHYCTL   = 2'h3;

   // System configuration field positions
   localparam int          SYS_RLN       = 8;
   localparam int          SYS_V1CM      = 4;
   localparam int          SYS_WEN       = 3;
   localparam int          SYS_WSM       = 2;
   localparam int          SYS_LPEN      = 1;
   localparam int          SYS_LPL       = 0;

   // Physical layer control field positions
   localparam int          PHY_CSK       = 11;
   localparam int          PHY_PNET      = 10;
   localparam int          PHY_OFFT      = 9;

   // Reset values of the stored fields
   localparam logic        RST_RLN       = 1'h1;
   localparam logic        RST_V1CM      = 1'h0;
   localparam logic        RST_WEN       = 1'h0;
   localparam logic        RST_WSM       = 1'h0;
   localparam logic        RST_LPEN      = 1'h0;
   localparam logic        RST_LPL       = 1'h0;
   localparam logic        RST_CSK       = 1'h0;
   localparam logic        RST_PNET      = 1'h0;
   localparam logic        RST_OFFT      = 1'h0;

   // Reply words keep the header bits cleared
   localparam logic [15:0] REPLY_MASK    = 16'h1FFF;

   // Off-line idle period codes
   localparam logic [1:0]  OFFL_SHORT    = 2'h0;
   localparam logic [1:0]  OFFL_LONG     = 2'h1;
   localparam logic [1:0]  OFFL_EXT      = 2'h2;

   // Reset lengthening times and their cycle counts
   localparam int          CLK_MHZ       = 25;
   localparam int          RST_SHORT_US  = 1000;
   localparam int          RST_LONG_US   = 20000;
   localparam int          RST_SHORT_CYC = RST_SHORT_US * CLK_MHZ;
   localparam int          RST_LONG_CYC  = RST_LONG_US * CLK_MHZ;

endpackage : sbc_cfg_pkg

// >>> src/sbc_cfg_regs.sv
// System configuration and physical layer control register bank of the system basis chip.
// Assumes the serial master sends whole 16-bit frames and that mode entry events
// arrive as one-cycle pulses from the mode controller.
//
// Notes on behaviour
// - Monitor bit one: rising supply current resets if watchdog was off in Standby.
// - Wake enable zero: wake input off, wake status flags held unchanged.
// - Wake sample bit chooses cyclic sampling (one) or continuous sampling (zero).
// - Inhibit/limp enable one drives the pin; zero leaves it floating.
// - With enable set, pin follows the inhibit/limp level bit.
// - Entering Restart or Fail-safe mode sets the long reset length bit.
// - Short external reset pulses are stretched to the programmed reset length.
// - Address pattern 11 selects the physical layer control register.
// - Read select returns general purpose feedback 1 or control feedback.
// - Read-only bit returns data without updating physical layer control.
// - Supply keep bit holds the CAN supply on in Off-line mode.
// - Partial network bit selects Listen mode; cleared entering On-line or Active.
// - Timeout bit one selects the long idle period, extended after wake-up.
// - Address pattern 10 selects the system configuration register.
// - Timeout bit zero selects the short idle period, extended after wake-up.
// - Read-only configuration access returns selected register, contents kept.
`timescale 1ns/1ps
module sbc_cfg_regs
#(
   parameter int RST_SHORT_CYC = sbc_cfg_pkg::RST_SHORT_CYC,
   parameter int RST_LONG_CYC  = sbc_cfg_pkg::RST_LONG_CYC
)
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        nrst_in,
   // Serial interface
   input  wire logic        spi_clk_in,
   input  wire logic        spi_csn_in,
   input  wire logic        spi_mosi_in,
   output logic             spi_miso_out,
   output logic             spi_miso_oe_out,
   // General purpose feedback words
   input  wire logic [15:0] gp_feedback0_in,
   input  wire logic [15:0] gp_feedback1_in,
   // Mode events and states
   input  wire logic        restart_entry_in,
   input  wire logic        failsafe_entry_in,
   input  wire logic        can_online_entry_in,
   input  wire logic        can_active_entry_in,
   input  wire logic        can_offline_mode_in,
   input  wire logic        can_wake_event_in,
   input  wire logic        standby_mode_in,
   input  wire logic        watchdog_off_in,
   input  wire logic        mcu_supply_current_rise_in,
   // Wake input
   input  wire logic        wake_pin_in,
   input  wire logic        wake_cyclic_tick_in,
   input  wire logic        wake_status_clear_in,
   output logic             wake_edge_status_out,
   output logic             wake_level_status_out,
   // Inhibit/limp pin
   output logic             inhibit_limp_output_out,
   output logic             inhibit_limp_oe_out,
   // Reset line, open drain
   input  wire logic        rstn_pin_in,
   output logic             rstn_pin_out,
   output logic             rstn_pin_oe_out,
   // Supervisor and transceiver controls
   output logic             mcu_reset_request_out,
   output logic             watchdog_reactivate_out,
   output logic             can_supply_enable_out,
   output logic             partial_network_listen_out,
   output logic [1:0]       offline_period_out,
   output logic             reset_length_select_out
);

   logic        hdr_valid;
   logic [2:0]  hdr;
   logic        frame_valid;
   logic [15:0] frame;
   logic [15:0] tx_word_q;
   logic        rln_q;
   logic        v1cm_q;
   logic        wen_q;
   logic        wsm_q;
   logic        lpen_q;
   logic        lpl_q;
   logic        csk_q;
   logic        pnet_q;
   logic        offt_q;
   logic        wake_ext_q;
   logic        wake_prev_q;
   logic        rst_prev_q;
   logic [31:0] stretch_q;
   logic        sys_wr;
   logic        phy_wr;
   logic        wake_take;
   logic        rst_trig;

   // Word read back from a feedback register, header bits cleared
   function automatic logic [15:0] fb_word(input logic [15:0] w);
      return w & sbc_cfg_pkg::REPLY_MASK;
   endfunction : fb_word

   // Frame engine
   sbc_spi_frame u_frame
   (
      .core_clk_in     (core_clk_in),
      .nrst_in         (nrst_in),
      .spi_clk_in      (spi_clk_in),
      .spi_csn_in      (spi_csn_in),
      .spi_mosi_in     (spi_mosi_in),
      .spi_miso_out    (spi_miso_out),
      .spi_miso_oe_out (spi_miso_oe_out),
      .tx_word_in      (tx_word_q),
      .hdr_valid_out   (hdr_valid),
      .hdr_out         (hdr),
      .frame_valid_out (frame_valid),
      .frame_out       (frame)
   );

   // Writes need a whole frame with the read-only bit clear
   assign sys_wr = frame_valid && frame[15:14] == sbc_cfg_pkg::ADDR_SYSCFG
                   && !frame[sbc_cfg_pkg::RDO_BIT];
   assign phy_wr = frame_valid && frame[15:14] == sbc_cfg_pkg::ADDR_PHYCTL
                   && !frame[sbc_cfg_pkg::RDO_BIT];

   // Reply word chosen once the header bits are in
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         tx_word_q <= 16'h0;
      else if (hdr_valid)
      begin
         case (hdr[2:1])
            sbc_cfg_pkg::ADDR_SYSCFG:
               tx_word_q <= hdr[0] ? fb_word(gp_feedback0_in)
                            : fb_word({7'h0, rln_q, 3'h0, v1cm_q, wen_q, wsm_q, lpen_q, lpl_q});
            sbc_cfg_pkg::ADDR_PHYCTL:
               tx_word_q <= hdr[0] ? fb_word(gp_feedback1_in)
                            : fb_word({4'h0, csk_q, pnet_q, offt_q, 9'h0});
            default:
               tx_word_q <= 16'h0;
         endcase
      end
   end

   // System configuration fields; mode entry sets the long reset length over a write
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rln_q  <= sbc_cfg_pkg::RST_RLN;
         v1cm_q <= sbc_cfg_pkg::RST_V1CM;
         wen_q  <= sbc_cfg_pkg::RST_WEN;
         wsm_q  <= sbc_cfg_pkg::RST_WSM;
         lpen_q <= sbc_cfg_pkg::RST_LPEN;
         lpl_q  <= sbc_cfg_pkg::RST_LPL;
      end
      else
      begin
         if (sys_wr)
         begin
            rln_q  <= frame[sbc_cfg_pkg::SYS_RLN];
            v1cm_q <= frame[sbc_cfg_pkg::SYS_V1CM];
            wen_q  <= frame[sbc_cfg_pkg::SYS_WEN];
            wsm_q  <= frame[sbc_cfg_pkg::SYS_WSM];
            lpen_q <= frame[sbc_cfg_pkg::SYS_LPEN];
            lpl_q  <= frame[sbc_cfg_pkg::SYS_LPL];
         end
         if (restart_entry_in || failsafe_entry_in)
            rln_q <= 1'h1;
      end
   end

   // Physical layer control fields; mode entry clears partial networking over a write
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         csk_q  <= sbc_cfg_pkg::RST_CSK;
         pnet_q <= sbc_cfg_pkg::RST_PNET;
         offt_q <= sbc_cfg_pkg::RST_OFFT;
      end
      else
      begin
         if (phy_wr)
         begin
            csk_q  <= frame[sbc_cfg_pkg::PHY_CSK];
            pnet_q <= frame[sbc_cfg_pkg::PHY_PNET];
            offt_q <= frame[sbc_cfg_pkg::PHY_OFFT];
         end
         if (can_online_entry_in || can_active_entry_in)
            pnet_q <= 1'h0;
      end
   end

   // Wake input sampled continuously or on the cyclic tick, frozen when disabled
   assign wake_take = wen_q && (!wsm_q || wake_cyclic_tick_in);
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wake_prev_q           <= 1'h1;
         wake_edge_status_out  <= 1'h0;
         wake_level_status_out <= 1'h0;
      end
      else
      begin
         if (wake_take)
         begin
            wake_prev_q           <= wake_pin_in;
            wake_level_status_out <= wake_pin_in;
         end
         if (wake_take && wake_prev_q && !wake_pin_in)
            wake_edge_status_out <= 1'h1;
         else if (wake_status_clear_in && wen_q)
            wake_edge_status_out <= 1'h0;
      end
   end

   // Inhibit/limp pin drive and level
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         inhibit_limp_oe_out     <= 1'h0;
         inhibit_limp_output_out <= 1'h0;
      end
      else
      begin
         inhibit_limp_oe_out     <= lpen_q;
         inhibit_limp_output_out <= lpen_q & lpl_q;
      end
   end

   // Supply current monitor outcome in Standby: reset with the watchdog off and monitor bit set, else watchdog reactivation
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         mcu_reset_request_out   <= 1'h0;
         watchdog_reactivate_out <= 1'h0;
      end
      else
      begin
         mcu_reset_request_out   <= mcu_supply_current_rise_in && standby_mode_in
                                    && watchdog_off_in && v1cm_q;
         watchdog_reactivate_out <= mcu_supply_current_rise_in && standby_mode_in
                                    && !(watchdog_off_in && v1cm_q);
      end
   end

   // Reset line stretching; our own drive never retriggers it
   assign rst_trig = (rst_prev_q && !rstn_pin_in && !rstn_pin_oe_out) || mcu_reset_request_out;
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_prev_q      <= 1'h1;
         stretch_q       <= 32'h0;
         rstn_pin_oe_out <= 1'h0;
         rstn_pin_out    <= 1'h0;
      end
      else
      begin
         rst_prev_q   <= rstn_pin_in;
         rstn_pin_out <= 1'h0;
         if (rst_trig)
         begin
            stretch_q       <= rln_q ? 32'(RST_LONG_CYC - 1) : 32'(RST_SHORT_CYC - 1);
            rstn_pin_oe_out <= 1'h1;
         end
         else if (stretch_q != 32'h0)
            stretch_q <= stretch_q - 32'h1;
         else
            rstn_pin_oe_out <= 1'h0;
      end
   end

   // Transceiver controls, wake extension held until Off-line mode is reached
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wake_ext_q                 <= 1'h0;
         can_supply_enable_out      <= 1'h1;
         partial_network_listen_out <= 1'h0;
         offline_period_out         <= sbc_cfg_pkg::OFFL_SHORT;
         reset_length_select_out    <= sbc_cfg_pkg::RST_RLN;
      end
      else
      begin
         if (can_wake_event_in)
            wake_ext_q <= 1'h1;
         else if (can_offline_mode_in)
            wake_ext_q <= 1'h0;
         can_supply_enable_out      <= !can_offline_mode_in || csk_q;
         partial_network_listen_out <= pnet_q;
         offline_period_out         <= wake_ext_q ? sbc_cfg_pkg::OFFL_EXT
                                       : offt_q ? sbc_cfg_pkg::OFFL_LONG
                                       : sbc_cfg_pkg::OFFL_SHORT;
         reset_length_select_out    <= rln_q;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_sys_write;
      sys_wr;
   endsequence
   sequence s_pins_follow;
      ##2 inhibit_limp_oe_out == $past(frame[sbc_cfg_pkg::SYS_LPEN], 2)
      && inhibit_limp_output_out == ($past(frame[sbc_cfg_pkg::SYS_LPEN], 2)
                                     & $past(frame[sbc_cfg_pkg::SYS_LPL], 2));
   endsequence
   property p_pins_follow;
      s_sys_write ##0 !$rose(restart_entry_in) |-> s_pins_follow;
   endproperty
   a_pins_follow: assert property (p_pins_follow) else $error("inhibit pin not following write");
   property p_phy_ro;
      frame_valid && frame[15:14] == sbc_cfg_pkg::ADDR_PHYCTL && frame[sbc_cfg_pkg::RDO_BIT]
      && !can_online_entry_in && !can_active_entry_in |=> $stable({csk_q, pnet_q, offt_q});
   endproperty
   a_phy_ro: assert property (p_phy_ro) else $error("read-only access changed control");
   property p_phy_wr;
      phy_wr && !can_online_entry_in && !can_active_entry_in
      |=> ##1 can_supply_enable_out == (!$past(can_offline_mode_in) || $past(frame[11], 2));
   endproperty
   a_phy_wr: assert property (p_phy_wr) else $error("supply control not taken");
   property p_sys_ro;
      frame_valid && frame[15:14] == sbc_cfg_pkg::ADDR_SYSCFG && frame[sbc_cfg_pkg::RDO_BIT]
      |=> $stable({v1cm_q, wen_q, wsm_q, lpen_q, lpl_q});
   endproperty
   a_sys_ro: assert property (p_sys_ro) else $error("read-only access changed configuration");
   property p_rlc_set;
      restart_entry_in || failsafe_entry_in |=> ##1 reset_length_select_out;
   endproperty
   a_rlc_set: assert property (p_rlc_set) else $error("reset length not set on entry");
   property p_partial_network_listen_clr;
      can_online_entry_in |=> ##1 !partial_network_listen_out;
   endproperty
   a_partial_network_listen_clr: assert property (p_partial_network_listen_clr) else $error("listen bit not cleared");
   property p_wake_hold;
      !wen_q |=> $stable(wake_edge_status_out) && $stable(wake_level_status_out);
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake flags moved while disabled");
   property p_stretch;
      rst_prev_q && !rstn_pin_in && !rstn_pin_oe_out |=> rstn_pin_oe_out [*8];
   endproperty
   a_stretch: assert property (p_stretch) else $error("reset pulse not stretched");
   property p_rrs;
      hdr_valid && hdr == 3'h7 |=> tx_word_q == fb_word($past(gp_feedback1_in));
   endproperty
   a_rrs: assert property (p_rrs) else $error("wrong feedback word selected");
   property p_offl;
      !wake_ext_q |=> offline_period_out == ($past(offt_q) ? sbc_cfg_pkg::OFFL_LONG
                                                           : sbc_cfg_pkg::OFFL_SHORT);
   endproperty
   a_offl: assert property (p_offl) else $error("off-line period wrong");

endmodule : sbc_cfg_regs

// >>> src/sbc_spi_frame.sv
// Serial frame engine: collects one 16-bit full-duplex frame and shifts a reply out.
// Assumes serial pins synchronous to the core clock, clock idle low, data taken on
// the rising edge and changed on the falling edge, half period of two core clocks or more.
`timescale 1ns/1ps
module sbc_spi_frame
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        nrst_in,
   // Serial pins
   input  wire logic        spi_clk_in,
   input  wire logic        spi_csn_in,
   input  wire logic        spi_mosi_in,
   output logic             spi_miso_out,
   output logic             spi_miso_oe_out,
   // Reply word and received data
   input  wire logic [15:0] tx_word_in,
   output logic             hdr_valid_out,
   output logic [2:0]       hdr_out,
   output logic             frame_valid_out,
   output logic [15:0]      frame_out
);

   logic        sclk_q;
   logic        csn_q;
   logic [4:0]  cnt_q;
   logic [15:0] shift_q;
   logic        rise;
   logic        fall;

   // Edge detection on the serial clock
   assign rise = spi_clk_in & ~sclk_q;
   assign fall = ~spi_clk_in & sclk_q;

   // Previous pin levels
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sclk_q <= 1'h0;
         csn_q  <= 1'h1;
      end
      else
      begin
         sclk_q <= spi_clk_in;
         csn_q  <= spi_csn_in;
      end
   end

   // Shift register, bit count and header pulse
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cnt_q         <= 5'h0;
         shift_q       <= 16'h0;
         hdr_valid_out <= 1'h0;
         hdr_out       <= 3'h0;
      end
      else
      begin
         hdr_valid_out <= 1'h0;
         if (csn_q && !spi_csn_in)
         begin
            cnt_q   <= 5'h0;
            shift_q <= 16'h0;
         end
         else if (!spi_csn_in && rise && cnt_q < 5'(sbc_cfg_pkg::FRAME_BITS))
         begin
            shift_q <= {shift_q[14:0], spi_mosi_in};
            cnt_q   <= cnt_q + 5'h1;
            if (cnt_q == 5'(sbc_cfg_pkg::HDR_BITS - 1))
            begin
               hdr_valid_out <= 1'h1;
               hdr_out       <= {shift_q[1:0], spi_mosi_in};
            end
         end
      end
   end

   // Whole frames only are passed on at deselect
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         frame_valid_out <= 1'h0;
         frame_out       <= 16'h0;
      end
      else
      begin
         frame_valid_out <= !csn_q && spi_csn_in && cnt_q == 5'(sbc_cfg_pkg::FRAME_BITS);
         if (!csn_q && spi_csn_in)
            frame_out <= shift_q;
      end
   end

   // Reply bits change on the falling serial clock edge
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         spi_miso_out    <= 1'h0;
         spi_miso_oe_out <= 1'h0;
      end
      else
      begin
         spi_miso_oe_out <= ~spi_csn_in;
         if (csn_q && !spi_csn_in)
            spi_miso_out <= 1'h0;
         else if (!spi_csn_in && fall && cnt_q != 5'h0 && cnt_q < 5'(sbc_cfg_pkg::FRAME_BITS))
            spi_miso_out <= tx_word_in[4'(15 - int'(cnt_q))];
      end
   end

endmodule : sbc_spi_frame

// >>> verification/sbc_spi_host.sv
// Serial master model: sends one 16-bit frame and collects the reply.
// Assumes the core clock paces the serial clock, two core cycles per phase.
`timescale 1ns/1ps
module sbc_spi_host
(
   // Clock
   input  wire logic core_clk_in,
   // Serial pins
   input  wire logic spi_miso_in,
   output logic      spi_clk_out,
   output logic      spi_csn_out,
   output logic      spi_mosi_out
);
   // Serial lines idle at start
   initial
   begin
      spi_clk_out  = 1'b0;
      spi_csn_out  = 1'b1;
      spi_mosi_out = 1'b0;
   end

   // One full-duplex frame, most significant bit first
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      logic [15:0] t;
      t = w;
      if (t[15:14] == sbc_cfg_pkg::ADDR_SYSCFG)
         t[5] = 1'b0;
      @(posedge core_clk_in);
      spi_csn_out <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      for (int i = 15; i >= 0; i--)
      begin
         spi_mosi_out <= t[i];
         repeat (2) @(posedge core_clk_in);
         r[i] = spi_miso_in;
         spi_clk_out <= 1'b1;
         repeat (2) @(posedge core_clk_in);
         if (i > 0)
            spi_clk_out <= 1'b0;
      end
      // Close the frame, then let the data line wander
      spi_csn_out  <= 1'b1;
      spi_mosi_out <= ~t[0];
      @(posedge core_clk_in);
      spi_clk_out <= 1'b0;
      repeat (3) @(posedge core_clk_in);
   endtask : xfer
endmodule : sbc_spi_host

// >>> verification/testbench.sv
// Self-checking bench for the configuration register bank.
// Assumes the serial master model drives frames; short reset counts in use.
`timescale 1ns/1ps
module testbench;
   localparam int RST_S = 10;
   localparam int RST_L = 20;
   int          n_errors = 0;
   int          checks   = 0;
   int          n_rst    = 0;
   int          n_wd     = 0;
   int          oe_cnt   = 0;
   int          a;
   int          b;
   integer      seed     = 22609;
   logic        core_clk_in, nrst_in, spi_clk_in, spi_csn_in, spi_mosi_in, spi_miso_out;
   logic [15:0] gp_feedback0_in, gp_feedback1_in, sys, phy, r;
   logic        restart_entry_in, failsafe_entry_in, can_online_entry_in, can_active_entry_in;
   logic        can_offline_mode_in, standby_mode_in, watchdog_off_in, mcu_supply_current_rise_in;
   logic        wake_pin_in, wake_cyclic_tick_in, wake_status_clear_in, rstn_pin_in, ext_low;
   logic        rstn_pin_oe_out, inhibit_limp_output_out, inhibit_limp_oe_out;
   logic        mcu_reset_request_out, watchdog_reactivate_out, can_supply_enable_out;
   logic        partial_network_listen_out, reset_length_select_out, wake_level_status_out;
   logic        spi_miso_oe_out, miso_line, can_wake_event_in, rstn_pin_out;
   logic [1:0]  offline_period_out;

   // Open-drain reset line; a released data line shows the inverse of its last bit
   assign rstn_pin_in = ~((rstn_pin_oe_out & ~rstn_pin_out) | ext_low);
   assign miso_line   = spi_miso_oe_out ? spi_miso_out : ~spi_miso_out;

   sbc_cfg_regs #(.RST_SHORT_CYC(RST_S), .RST_LONG_CYC(RST_L)) DUT
   (
      .core_clk_in, .nrst_in, .spi_clk_in, .spi_csn_in, .spi_mosi_in, .spi_miso_out,
      .spi_miso_oe_out, .gp_feedback0_in, .gp_feedback1_in, .restart_entry_in,
      .failsafe_entry_in, .can_online_entry_in, .can_active_entry_in, .can_offline_mode_in,
      .can_wake_event_in, .standby_mode_in, .watchdog_off_in, .mcu_supply_current_rise_in,
      .wake_pin_in, .wake_cyclic_tick_in, .wake_status_clear_in, .wake_edge_status_out(),
      .wake_level_status_out, .inhibit_limp_output_out, .inhibit_limp_oe_out, .rstn_pin_in,
      .rstn_pin_out, .rstn_pin_oe_out, .mcu_reset_request_out, .watchdog_reactivate_out,
      .can_supply_enable_out, .partial_network_listen_out, .offline_period_out,
      .reset_length_select_out
   );

   sbc_spi_host u_host
   (
      .core_clk_in,
      .spi_miso_in(miso_line),
      .spi_clk_out(spi_clk_in),
      .spi_csn_out(spi_csn_in),
      .spi_mosi_out(spi_mosi_in)
   );

   // Clock
   initial
   begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   // Pulse and stretch counters
   always @(posedge core_clk_in)
   begin
      if (nrst_in)
      begin
         n_rst  <= n_rst + int'(mcu_reset_request_out);
         n_wd   <= n_wd + int'(watchdog_reactivate_out);
         oe_cnt <= oe_cnt + int'(rstn_pin_oe_out);
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [15:0] reply(input logic [15:0] f);
      case (f[15:14])
         sbc_cfg_pkg::ADDR_SYSCFG: return f[13] ? gp_feedback0_in & sbc_cfg_pkg::REPLY_MASK : sys;
         sbc_cfg_pkg::ADDR_PHYCTL: return f[13] ? gp_feedback1_in & sbc_cfg_pkg::REPLY_MASK : phy;
         default: return 16'h0000;
      endcase
   endfunction : reply

   task automatic outs();
      chk(16'(inhibit_limp_oe_out), 16'(sys[1]));
      chk(16'(inhibit_limp_output_out), 16'(sys[1] & sys[0]));
      chk(16'(reset_length_select_out), 16'(sys[8]));
      chk(16'(partial_network_listen_out), 16'(phy[10]));
      chk(16'(can_supply_enable_out), 16'(!can_offline_mode_in | phy[11]));
      chk(16'(offline_period_out), phy[9] ? 16'(sbc_cfg_pkg::OFFL_LONG) : 16'h0000);
      if (sys[3] && (!sys[2] || wake_cyclic_tick_in))
         chk(16'(wake_level_status_out), 16'(wake_pin_in));
   endtask : outs

   task automatic frame(input logic [15:0] f);
      u_host.xfer(f, r);
      chk(r, reply(f));
      if (!f[12] && f[15:14] == sbc_cfg_pkg::ADDR_SYSCFG)
         sys = f & 16'h011F;
      if (!f[12] && f[15:14] == sbc_cfg_pkg::ADDR_PHYCTL)
         phy = f & 16'h0E00;
      repeat (4) @(posedge core_clk_in);
      outs();
   endtask : frame

   // One-cycle pulse on a mode event, supply event or the reset line
   task automatic pulse(input int k);
      @(posedge core_clk_in);
      case (k)
         0: restart_entry_in <= 1'b1;
         1: failsafe_entry_in <= 1'b1;
         2: can_online_entry_in <= 1'b1;
         3: can_active_entry_in <= 1'b1;
         4: mcu_supply_current_rise_in <= 1'b1;
         6: can_wake_event_in <= 1'b1;
         default: ext_low <= 1'b1;
      endcase
      @(posedge core_clk_in);
      {restart_entry_in, failsafe_entry_in, can_online_entry_in, can_active_entry_in} <= '0;
      {mcu_supply_current_rise_in, ext_low, can_wake_event_in} <= '0;
      repeat (4) @(posedge core_clk_in);
   endtask : pulse

   task automatic finish_test();
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   // Main sequence
   initial
   begin
      nrst_in = 1'b0;
      {restart_entry_in, failsafe_entry_in, can_online_entry_in, can_active_entry_in} = '0;
      {can_offline_mode_in, standby_mode_in, watchdog_off_in, mcu_supply_current_rise_in} = '0;
      {wake_pin_in, wake_cyclic_tick_in, wake_status_clear_in, ext_low, can_wake_event_in} = '0;
      {gp_feedback0_in, gp_feedback1_in} = '0;
      sys = 16'h0100;
      phy = 16'h0000;
      repeat (6) @(posedge core_clk_in);
      outs();
      nrst_in <= 1'b1;
      // Random frames to every address, with and without writing
      for (int n = 0; n < 40; n++)
      begin
         @(posedge core_clk_in);
         {can_offline_mode_in, standby_mode_in, watchdog_off_in, wake_pin_in} <= 4'($random(seed));
         {wake_cyclic_tick_in, wake_status_clear_in} <= 2'($random(seed));
         gp_feedback0_in <= 16'($random(seed));
         gp_feedback1_in <= 16'($random(seed));
         frame(16'($random(seed)));
      end
      // Mode entries force the long reset length
      for (int k = 0; k < 2; k++)
      begin
         frame(16'h8000);
         pulse(k);
         sys[8] = 1'b1;
         outs();
      end
      // On-line and Active entries clear partial networking
      for (int k = 2; k < 4; k++)
      begin
         frame(16'hC400);
         pulse(k);
         phy[10] = 1'b0;
         outs();
      end
      // Wake-up extends the off-line period until Off-line mode
      can_offline_mode_in <= 1'b0;
      pulse(6);
      chk(16'(offline_period_out), 16'(sbc_cfg_pkg::OFFL_EXT));
      can_offline_mode_in <= 1'b1;
      frame(16'hC200);
      // Supply current rise with the monitor bit set, short stretch
      standby_mode_in <= 1'b1;
      watchdog_off_in <= 1'b1;
      frame(16'h8010);
      a = n_rst;
      b = oe_cnt;
      pulse(4);
      repeat (20) @(posedge core_clk_in);
      chk(16'(n_rst - a), 16'h0001);
      chk(16'(oe_cnt - b), 16'(RST_S));
      // External spike stretched to the long length
      frame(16'h8100);
      b = oe_cnt;
      pulse(5);
      repeat (30) @(posedge core_clk_in);
      chk(16'(oe_cnt - b), 16'(RST_L));
      // Monitor bit cleared: watchdog only reactivated
      frame(16'h8000);
      a = n_wd;
      b = n_rst;
      pulse(4);
      repeat (20) @(posedge core_clk_in);
      chk(16'(n_wd - a), 16'h0001);
      chk(16'(n_rst - b), 16'h0000);
      finish_test();
   end

   // Watchdog against a hang
   initial
   begin
      #400000;
      n_errors++;
      finish_test();
   end
endmodule : testbench
